// file: core/tmcs_timer.v
// Operation
// - Cascaded single-shot: output takes output level bit at each timeout, holds between.
// - Cascaded single-shot: every timeout sets the timer flag.
// - Interval modes: output held low; flag follows timeout and gate edges.
// - Interval modes: initialization only while timer flag is clear.
// - Frequency mode: gate falling edge enables counter and initializes.
// - Frequency mode: counter decrements until interrupt, latch write or reset.
// - Frequency mode: flag on short period (pol 0) or long period (pol 1).
// - Frequency pol 1: early gate fall restarts; comparison repeats each cycle.
// - Pulse mode: flag on short low time (pol 0) or long (pol 1).
// - Pulse mode: gate rising edge disables the counter, keeping the width.
// - Status is read-only with timer and two port flags set by source.
// - Composite flag is OR of flags ANDed with enables, continuously.
// - Composite flag clear only when all enabled flags clear.
// - Soft reset bit or external reset clears the timer flag.
// - Every counter initialization clears the timer flag.
// - Interval modes: latch write clears the timer flag.
// - Counter MSB read clears flag only if previous status read saw it set.
// - Status bits three to six read zero.
// - Timer irq enable gates the timer flag into the composite flag.
// - Initialization loads counter from latches and clears the flag.
// - Clock after all zeros reloads counter; the mode logic decides the flag.
// - Soft reset presets counter, stops clocks, resets output and flag.
`include "tmcs_defs.vh"
module tmcs_timer #(
  parameter CNT_W = 16
) (
  input wire clk,
  input wire rst,
  input wire external_reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire gate_input_pin,
  input wire external_count_clock,
  input wire port_edge1_event,
  input wire port_edge2_event,
  output reg counter_output_pin,
  output wire irq_n
);
  // ****************************************************************
  // Bus decode
  // ****************************************************************
  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // The slave never stretches a transfer, so every access lasts one cycle.
  // Writes to the status word or to the counter bytes are refused with an error.
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire mapped = hit(paddr, `TMCS_OFF_STATUS) | hit(paddr, `TMCS_OFF_CTRL) |
    hit(paddr, `TMCS_OFF_CNT_MSB) | hit(paddr, `TMCS_OFF_CNT_LSB) |
    hit(paddr, `TMCS_OFF_LATCH);
  assign pready = 1'b1;
  assign pslverr = acc & (~mapped | (pwrite & (hit(paddr, `TMCS_OFF_STATUS) |
    hit(paddr, `TMCS_OFF_CNT_MSB) | hit(paddr, `TMCS_OFF_CNT_LSB))));
  wire wr_ctrl = wr & hit(paddr, `TMCS_OFF_CTRL);
  wire wr_latch = wr & hit(paddr, `TMCS_OFF_LATCH);
  wire rd_stat = psel & ~penable & ~pwrite & hit(paddr, `TMCS_OFF_STATUS);
  wire rd_msb = rd & hit(paddr, `TMCS_OFF_CNT_MSB);

  // ****************************************************************
  // State
  // ****************************************************************
  reg [9:0] ctrl_ff;
  reg [CNT_W-1:0] latch_ff;
  reg [CNT_W-1:0] cnt_ff;
  reg timer_flag_ff;
  wire [1:0] port_evt = {port_edge2_event, port_edge1_event};
  wire [1:0] port_flag;
  reg seen_ff;
  reg cen_ff;
  reg gate_ff;
  reg ext_ff;
  reg [2:0] presc_ff;
  reg tof_ff;

  wire sreset = ctrl_ff[`TMCS_B_SRST] | ~external_reset_n;
  wire intv = ctrl_ff[`TMCS_B_INTV];
  wire mid = ctrl_ff[`TMCS_B_MID];
  wire pol = ctrl_ff[`TMCS_B_POL];
  wire g_fall = gate_ff & ~gate_input_pin;
  wire g_rise = ~gate_ff & gate_input_pin;

  // ****************************************************************
  // Clock recognition
  // ****************************************************************
  // The external clock counts on its falling edge; the divider passes every eighth tick.
  wire src_tick = ctrl_ff[`TMCS_B_CLKSEL] ? 1'b1 : (ext_ff & ~external_count_clock);
  wire presc_done = ~ctrl_ff[`TMCS_B_PRESC] | (presc_ff == `TMCS_PRESC_LAST);
  wire tick = src_tick & presc_done & ~sreset;

  // ****************************************************************
  // Mode logic
  // ****************************************************************
  wire cont_mode = ~intv & ~mid & ~pol;
  wire cont_g = ~intv & mid & ~pol;
  wire casc = ~intv & ~mid & pol;
  wire norm = ~intv & mid & pol;
  wire freq = intv & ~mid;
  wire pulse = intv & mid;

  reg init;
  reg cen_set;
  reg cen_clr;
  reg count_en;
  always @* begin
    init = sreset;
    cen_set = 1'b0;
    cen_clr = 1'b0;
    count_en = 1'b0;
    if (cont_mode | casc) begin
      // These modes also reinitialize on a latch write.
      init = sreset | g_fall | wr_latch;
      count_en = cont_mode ? ~gate_input_pin : 1'b1;
    end else if (cont_g | norm) begin
      init = sreset | g_fall;
      count_en = cont_g ? ~gate_input_pin : 1'b1;
    end else if (freq) begin
      // A gate fall arms the counter, which runs until the flag, a latch write or a reset stops it.
      if (pol) begin
        init = sreset | (g_fall & ~timer_flag_ff);
      end else begin
        init = sreset | ((~cen_ff | (tof_ff & cen_ff)) & g_fall & ~timer_flag_ff);
      end
      cen_set = g_fall & ~wr_latch & ~sreset & ~timer_flag_ff;
      cen_clr = wr_latch | sreset | timer_flag_ff;
      count_en = cen_ff;
    end else if (pulse) begin
      // The counter runs only while the gate stays low.
      init = sreset | (g_fall & ~timer_flag_ff);
      cen_set = g_fall & ~wr_latch & ~sreset & ~timer_flag_ff & ~gate_input_pin;
      cen_clr = wr_latch | sreset | timer_flag_ff | gate_input_pin;
      count_en = cen_ff;
    end
  end

  // A timeout is a recognized clock that finds the count at zero.
  wire timeout = tick & count_en & (cnt_ff == {CNT_W{1'b0}}) & ~init;
  // Interval flag sources: pol 0 compares gate edge before timeout, pol 1 timeout first.
  reg iv_set;
  always @* begin
    iv_set = 1'b0;
    if (freq) begin
      iv_set = pol ? (timeout & cen_ff) : (g_fall & cen_ff & ~tof_ff);
    end else if (pulse) begin
      iv_set = pol ? (timeout & cen_ff & ~gate_input_pin) :
        (g_rise & cen_ff & ~tof_ff);
    end
  end
  wire flag_set = intv ? iv_set : timeout;
  wire host_clr = rd_msb & seen_ff;
  wire flag_clr = init | host_clr | (intv & wr_latch);

  // ****************************************************************
  // Input sampling
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      gate_ff <= 1'b1;
      ext_ff <= 1'b1;
    end else begin
      gate_ff <= gate_input_pin;
      ext_ff <= external_count_clock;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `TMCS_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= pwdata[9:0];
    end
  end

  // ****************************************************************
  // Latch
  // ****************************************************************
  // The soft reset bit leaves the latch alone; only the reset pin presets it.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_ff <= `TMCS_LATCH_RST;
    end else if (~external_reset_n) begin
      latch_ff <= `TMCS_LATCH_RST;
    end else if (wr_latch) begin
      latch_ff <= pwdata[CNT_W-1:0];
    end
  end

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      presc_ff <= 3'h0;
    end else if (sreset | ~ctrl_ff[`TMCS_B_PRESC]) begin
      presc_ff <= 3'h0;
    end else if (src_tick) begin
      presc_ff <= presc_ff + 3'h1;
    end
  end

  // ****************************************************************
  // Counter
  // ****************************************************************
  // A timeout reloads from the latch and leaves the flag to the mode logic.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= `TMCS_LATCH_RST;
      tof_ff <= 1'b0;
    end else if (init) begin
      cnt_ff <= latch_ff;
      tof_ff <= 1'b0;
    end else if (tick & count_en) begin
      if (cnt_ff == {CNT_W{1'b0}}) begin
        cnt_ff <= latch_ff;
        tof_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ****************************************************************
  // Counter enable
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cen_ff <= 1'b0;
    end else if (cen_clr) begin
      cen_ff <= 1'b0;
    end else if (cen_set) begin
      cen_ff <= 1'b1;
    end
  end

  // ****************************************************************
  // Timer flag
  // ****************************************************************
  // A set wins over a host clear; a reset always clears.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_flag_ff <= 1'b0;
    end else if (sreset) begin
      timer_flag_ff <= 1'b0;
    end else if (flag_set) begin
      timer_flag_ff <= 1'b1;
    end else if (flag_clr) begin
      timer_flag_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Status read record
  // ****************************************************************
  // The flag is recorded when the status word is captured, so a later set survives.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_ff <= 1'b0;
    end else if (rd_stat) begin
      seen_ff <= timer_flag_ff;
    end else if (rd_msb) begin
      seen_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Port flags
  // ****************************************************************
  // Port flags are sticky here; their clearing belongs to the port section.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_port
      reg flag_ff;
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          flag_ff <= 1'b0;
        end else if (port_evt[gi]) begin
          flag_ff <= 1'b1;
        end
      end
      assign port_flag[gi] = flag_ff;
    end
  endgenerate

  // ****************************************************************
  // Counter output
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      counter_output_pin <= 1'b0;
    end else if (sreset) begin
      counter_output_pin <= 1'b0;
    end else if (casc) begin
      if (timeout) begin
        counter_output_pin <= ctrl_ff[`TMCS_B_OUTLVL];
      end
    end else if (norm) begin
      if (init) begin
        counter_output_pin <= ctrl_ff[`TMCS_B_OUTLVL];
      end else if (timeout) begin
        counter_output_pin <= 1'b0;
      end
    end else if (~intv) begin
      if (timeout) begin
        counter_output_pin <= ctrl_ff[`TMCS_B_OUTLVL] & ~counter_output_pin;
      end else if (~ctrl_ff[`TMCS_B_OUTLVL]) begin
        counter_output_pin <= 1'b0;
      end
    end else begin
      counter_output_pin <= 1'b0;
    end
  end

  // ****************************************************************
  // Composite status and read data
  // ****************************************************************
  wire comp = (timer_flag_ff & ctrl_ff[`TMCS_B_IRQEN]) |
    (port_flag[0] & ctrl_ff[`TMCS_B_PE1EN]) | (port_flag[1] & ctrl_ff[`TMCS_B_PE2EN]);
  assign irq_n = ~comp;
  wire [7:0] status = {comp, 4'h0, port_flag, timer_flag_ff};

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Read data is chosen in the setup cycle and stands through the access cycle.
  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h00000000;
    if (hit(paddr, `TMCS_OFF_STATUS)) begin
      rd_word = {24'h000000, status};
    end else if (hit(paddr, `TMCS_OFF_CTRL)) begin
      rd_word = {22'h0, ctrl_ff};
    end else if (hit(paddr, `TMCS_OFF_CNT_MSB)) begin
      rd_word = {24'h000000, cnt_ff[15:8]};
    end else if (hit(paddr, `TMCS_OFF_CNT_LSB)) begin
      rd_word = {24'h000000, cnt_ff[7:0]};
    end else if (hit(paddr, `TMCS_OFF_LATCH)) begin
      rd_word = {16'h0000, latch_ff};
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_word;
    end
  end
endmodule // tmcs_timer

// file: pkg/tmcs_defs.vh
`ifndef TMCS_DEFS_VH
`define TMCS_DEFS_VH
// ****************************************************************
// APB register map
// ****************************************************************
`define TMCS_OFF_STATUS 8'h00
`define TMCS_OFF_CTRL 8'h04
`define TMCS_OFF_CNT_MSB 8'h08
`define TMCS_OFF_CNT_LSB 8'h0C
`define TMCS_OFF_LATCH 8'h10
// ****************************************************************
// Control bit positions
// ****************************************************************
`define TMCS_B_SRST 0
`define TMCS_B_CLKSEL 1
`define TMCS_B_PRESC 2
`define TMCS_B_INTV 3
`define TMCS_B_MID 4
`define TMCS_B_POL 5
`define TMCS_B_IRQEN 6
`define TMCS_B_OUTLVL 7
`define TMCS_B_PE1EN 8
`define TMCS_B_PE2EN 9
// ****************************************************************
// Status bit positions and reset values
// ****************************************************************
`define TMCS_S_TIMER 0
`define TMCS_S_PE1 1
`define TMCS_S_PE2 2
`define TMCS_S_COMP 7
`define TMCS_CTRL_RST 10'h001
`define TMCS_LATCH_RST 16'hFFFF
`define TMCS_PRESC_LAST 3'h7
`endif

// file: test/tmcs_timer_properties.sv
`include "tmcs_defs.vh"
module tmcs_timer_chk(
  input wire clk,
  input wire rst,
  input wire external_reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire counter_output_pin,
  input wire irq_n
);
  logic [9:0] ctl_ff;
  logic [15:0] lat_ff;
  wire acc = psel && penable && pready;
  wire wr_acc = acc && pwrite;
  wire rd_st = acc && !pwrite && paddr == `TMCS_OFF_STATUS;
  wire casc = ctl_ff[5:3] == 3'h4 && !ctl_ff[0];
  // Shadow copies of control and latch, as software wrote them.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_ff <= `TMCS_CTRL_RST;
      lat_ff <= `TMCS_LATCH_RST;
    end else begin
      if (wr_acc && paddr == `TMCS_OFF_CTRL)
        ctl_ff <= pwdata[9:0];
      if (!external_reset_n)
        lat_ff <= `TMCS_LATCH_RST;
      else if (wr_acc && paddr == `TMCS_OFF_LATCH)
        lat_ff <= pwdata[15:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_UNUSED_ZERO: assert property (
    rd_st |-> prdata[6:3] == 4'h0) else $error("unused status bits set");
  AST_COMP_PIN: assert property (
    rd_st |-> prdata[7] == !$past(irq_n)) else $error("composite bit and pin differ");
  AST_MASKED: assert property (
    ctl_ff[9:8] == 2'h0 && !ctl_ff[6] |-> irq_n) else $error("irq while masked");
  AST_SRST_OUT: assert property (
    ctl_ff[0] && $past(ctl_ff[0]) |-> !counter_output_pin) else $error("output in reset");
  AST_SRST_FLAG: assert property (
    ctl_ff[0] && $past(ctl_ff[0]) && ctl_ff[9:8] == 2'h0 |-> irq_n)
    else $error("timer flag in reset");
  AST_PRESET_MSB: assert property (
    acc && !pwrite && paddr == `TMCS_OFF_CNT_MSB && ctl_ff[0] && $past(ctl_ff[0], 2)
    |-> prdata[7:0] == $past(lat_ff[15:8], 2)) else $error("counter not preset");
  AST_RO_ERR: assert property (
    wr_acc && (paddr == `TMCS_OFF_STATUS || paddr == `TMCS_OFF_CNT_MSB)
    |-> pslverr) else $error("read-only write accepted");
  AST_CASC_OUT: assert property (
    casc && $past(casc) && $changed(counter_output_pin)
    |-> counter_output_pin == $past(ctl_ff[7])) else $error("output not level bit");
endmodule // tmcs_timer_chk
bind tmcs_timer tmcs_timer_chk tmcs_timer_chk_i (.clk, .rst, .external_reset_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .counter_output_pin,
  .irq_n);

// file: test/tmcs_host_bfm.sv
module tmcs_host_bfm(
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // tmcs_host_bfm

// file: test/tb_timer_modes_and_composite_status.sv
`include "tmcs_defs.vh"
module tb_timer_modes_and_composite_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic external_reset_n = 1'b1;
  logic gate_input_pin = 1'b1;
  logic port_edge1_event = 1'b0;
  logic port_edge2_event = 1'b0;
  wire psel, penable, pwrite, pready, pslverr, counter_output_pin, irq_n;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata;
  logic [31:0] r;
  logic e;
  logic [15:0] n;
  logic [7:0] lo;
  logic [2:0] k;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  tmcs_timer tmcs_timer_i (.clk, .rst, .external_reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .gate_input_pin,
    .external_count_clock(1'b0), .port_edge1_event, .port_edge2_event,
    .counter_output_pin, .irq_n);
  tmcs_host_bfm tmcs_host_bfm_i (.clk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr);
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    tmcs_host_bfm_i.xfer(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    tmcs_host_bfm_i.xfer(1'b1, a, d, r, e);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 400 && irq_n !== 1'b0; i++)
      @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // The whole run needs about 1000 cycles, so 20000 marks a hang.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    rst <= 1'b1;
    void'($urandom(35429));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`TMCS_OFF_CTRL, 32'h1);
    rd(`TMCS_OFF_LATCH, 32'hFFFF);
    rd(8'h14, 32'h0);
    wr(`TMCS_OFF_STATUS, 32'hFF);
    chk({31'h0, e}, 32'h1);
    $display("reset test done");
    n = 16'(40 + $urandom % 40);
    wr(`TMCS_OFF_LATCH, {16'h0, n});
    wr(`TMCS_OFF_CTRL, 32'hE2);
    wait_irq();
    chk({31'h0, counter_output_pin, irq_n}, 32'h2);
    rd(`TMCS_OFF_CNT_MSB, 32'h0);
    chk({31'h0, irq_n}, 32'h0);
    rd(`TMCS_OFF_STATUS, 32'h81);
    rd(`TMCS_OFF_CNT_MSB, 32'h0);
    #1;
    chk({31'h0, irq_n}, 32'h1);
    wr(`TMCS_OFF_CTRL, 32'h62);
    chk({31'h0, counter_output_pin}, 32'h1);
    wait_irq();
    chk({31'h0, counter_output_pin, irq_n}, 32'h0);
    wr(`TMCS_OFF_CTRL, 32'h22);
    rd(`TMCS_OFF_STATUS, 32'h1);
    wr(`TMCS_OFF_CTRL, 32'h62);
    #1;
    chk({31'h0, irq_n}, 32'h0);
    external_reset_n <= 1'b0;
    @(posedge clk);
    external_reset_n <= 1'b1;
    rd(`TMCS_OFF_STATUS, 32'h0);
    rd(`TMCS_OFF_LATCH, 32'hFFFF);
    n = 16'($urandom);
    wr(`TMCS_OFF_CTRL, 32'h1);
    wr(`TMCS_OFF_LATCH, {16'h0, n});
    rd(`TMCS_OFF_CNT_MSB, {24'h0, n[15:8]});
    $display("cascade test done");
    // Bit 0 of k: gate low time beyond timeout, bit 1: polarity, bit 2: pulse mode.
    for (int c = 0; c < 8; c++) begin
      k = 3'(c);
      lo = k[0] ? 8'(100 + $urandom % 50) : 8'(5 + $urandom % 15);
      wr(`TMCS_OFF_CTRL, 32'h1);
      wr(`TMCS_OFF_LATCH, 32'h3C);
      wr(`TMCS_OFF_CTRL, {26'h0, k[1], k[2], 4'hA});
      gate_input_pin <= 1'b0;
      repeat (lo) @(posedge clk);
      gate_input_pin <= 1'b1;
      repeat (10) @(posedge clk);
      gate_input_pin <= 1'b0;
      repeat (4) @(posedge clk);
      rd(`TMCS_OFF_STATUS, {31'h0, ~k[0] ^ k[1]});
      if (~k[0] ^ k[1]) begin
        wr(`TMCS_OFF_LATCH, 32'h3C);
        rd(`TMCS_OFF_STATUS, 32'h0);
      end
      gate_input_pin <= 1'b1;
    end
    $display("interval test done");
    wr(`TMCS_OFF_CTRL, 32'h1);
    port_edge2_event <= 1'b1;
    @(posedge clk);
    port_edge2_event <= 1'b0;
    rd(`TMCS_OFF_STATUS, 32'h4);
    wr(`TMCS_OFF_CTRL, 32'h201);
    #1;
    chk({31'h0, irq_n}, 32'h0);
    port_edge1_event <= 1'b1;
    @(posedge clk);
    port_edge1_event <= 1'b0;
    rd(`TMCS_OFF_STATUS, 32'h86);
    $display("port test done");
    final_report();
  end
endmodule // tb_timer_modes_and_composite_status
